// >>> bcc_access_side_protocol_fsm_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module bcc_access_side_protocol_fsm_tb_top;
  logic       clock = 1'b0;
  logic       sys_rst = 1'b1;
  logic [7:0] in_v = 8'h00;
  logic [7:0] out_v;
  logic       mg_fault_req = 1'b0;
  logic       ack_en = 1'b0;
  logic [3:0] ack_dly = 4'h2;
  logic       rx_fault_ack, tx_fault, pending, ind_fault_conf, ind_fault_err;
  int         err_total = 0;
  int         checks_done = 0;
  int         cyc = 0;
  // short timer keeps the fault walk to fifteen cycles
  bcc_an_fsm #(.FRT_CYCLES(32'h0000_0004)) i_dut (
    .clock(clock), .sys_rst(sys_rst),
    .rx_alloc(in_v[7]), .rx_dealloc(in_v[6]), .rx_audit(in_v[5]),
    .rx_fault_ack(rx_fault_ack), .mg_alloc_cmpl(in_v[4]), .mg_alloc_rej(in_v[3]),
    .mg_dealloc_cmpl(in_v[2]), .mg_dealloc_rej(in_v[1]), .mg_audit_resp(in_v[0]),
    .mg_fault_req(mg_fault_req), .ind_alloc(out_v[7]), .ind_dealloc(out_v[6]),
    .ind_audit(out_v[5]), .ind_fault_conf(ind_fault_conf), .ind_fault_err(ind_fault_err),
    .tx_alloc_cmpl(out_v[4]), .tx_alloc_rej(out_v[3]), .tx_dealloc_cmpl(out_v[2]),
    .tx_dealloc_rej(out_v[1]), .tx_audit_cmpl(out_v[0]), .tx_fault(tx_fault),
    .pending(pending));
  bcc_le_peer i_peer (.clock(clock), .ack_en(ack_en), .ack_dly(ack_dly),
    .tx_fault(tx_fault), .rx_fault_ack(rx_fault_ack));
  always #50 clock = ~clock;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  // one event at a time; the answer shows at the next falling edge
  task automatic t_oper();
    for (int i = 0; i < 8; i++) begin
      @(negedge clock) in_v = 8'h01 << i;
      @(negedge clock) in_v = 8'h00;
      chk(out_v, 8'h01 << i, "relay");
      chk(pending, 1'b0, "state");
    end
    $display("test oper done");
  endtask : t_oper
  // fault walk; events thrown at the block while it waits for the peer
  task automatic t_fault(input logic ack);
    ack_en = ack;
    for (int n = 0; n <= 14; n++) begin
      @(negedge clock);
      chk(out_v, 8'h00, "ignored");
      chk(tx_fault, (n == 1) || (!ack && n == 6), "fault msg");
      chk(pending, ack ? (n >= 1 && n <= 3) : (n >= 1 && n <= 10), "pend");
      chk(ind_fault_conf, ack && n == 4, "conf");
      chk(ind_fault_err, !ack && n == 11, "err");
      mg_fault_req = (n <= 3);
      in_v = (n >= 1 && n <= 3) ? 8'hff : 8'h00;
    end
    $display("test fault ack=%0d done", ack);
  endtask : t_fault
  // all operational events in one cycle, then a reset while the report waits
  task automatic t_burst();
    ack_en = 1'b1;
    @(negedge clock);
    in_v = 8'hff;
    mg_fault_req = 1'b1;
    @(negedge clock);
    in_v = 8'h00;
    mg_fault_req = 1'b0;
    sys_rst = 1'b1;
    chk(out_v, 8'hff, "burst relay");
    chk(tx_fault, 1'b1, "burst fault");
    chk(pending, 1'b1, "burst pend");
    @(negedge clock);
    sys_rst = 1'b0;
    chk(pending, 1'b0, "reset pend");
    chk(tx_fault, 1'b0, "reset fault");
    // the late peer ack lands while operational and must be dropped
    for (int n = 0; n < 8; n++) begin
      @(negedge clock);
      chk(out_v, 8'h00, "late quiet");
      chk(ind_fault_conf, 1'b0, "late conf");
      chk(pending, 1'b0, "late pend");
    end
    ack_en = 1'b0;
    $display("test burst done");
  endtask : t_burst
  // stop a hung run
  always @(posedge clock) begin
    cyc++;
    if (cyc == 500) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    repeat (5) @(negedge clock);
    sys_rst = 1'b0;
    @(negedge clock);
    chk(pending, 1'b0, "reset");
    t_oper();
    t_burst();
    t_fault(1'b1);
    t_fault(1'b0);
    t_fault(1'b0);
    report_and_stop();
  end
endmodule : bcc_access_side_protocol_fsm_tb_top
`default_nettype wire

// >>> bcc_an_fsm.sv
// Overview of operation
// R1: two-state machine, starts operational
// R2: peer messages become management indications
// R3: management complete responses sent to peer
// R4: management reject responses sent to peer
// R5: fault request sends fault, starts timer
// R6: acknowledge confirms, stops timer, back operational
// R7: first expiry resends fault, restarts timer
// R8: second expiry reports error, back operational
// R9: unexpected events ignored, state unchanged
// R10: timer length parameter, expiry count cleared
`timescale 1ns/100ps
`default_nettype none
`include "bcc_params.svh"
module bcc_an_fsm #(
  parameter logic [31:0] FRT_CYCLES = `BCC_FRT_CYCLES
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  // messages from the exchange peer
  input  wire logic rx_alloc,
  input  wire logic rx_dealloc,
  input  wire logic rx_audit,
  input  wire logic rx_fault_ack,
  // management responses and fault request
  input  wire logic mg_alloc_cmpl,
  input  wire logic mg_alloc_rej,
  input  wire logic mg_dealloc_cmpl,
  input  wire logic mg_dealloc_rej,
  input  wire logic mg_audit_resp,
  input  wire logic mg_fault_req,
  // indications to management
  output logic      ind_alloc,
  output logic      ind_dealloc,
  output logic      ind_audit,
  output logic      ind_fault_conf,
  output logic      ind_fault_err,
  // messages to the exchange peer, then the pending flag
  output logic      tx_alloc_cmpl,
  output logic      tx_alloc_rej,
  output logic      tx_dealloc_cmpl,
  output logic      tx_dealloc_rej,
  output logic      tx_audit_cmpl,
  output logic      tx_fault,
  output logic      pending
);
  // ==========================================================
  // fault report timer
  // the timer sits apart so its reload and stop can be checked alone
  bcc_tmr_if tif ();

  bcc_timer #(.CYCLES(FRT_CYCLES)) u_tmr (
    .clock   (clock),
    .sys_rst (sys_rst),
    .tif     (tif)
  );

  // ==========================================================
  // state and output registers
  bcc_pkg::bcc_state_t st_q;
  bcc_pkg::bcc_state_t st_d;
  logic [1:0]          nexp_q;
  logic [1:0]          nexp_d;
  logic [10:0]         out_q;
  logic [10:0]         out_d;
  logic                start_d;
  logic                stop_d;
  logic                pending_d;

  // ==========================================================
  // helpers
  // expiry count step; saturates so a stray pulse cannot wrap to zero
  function automatic logic [1:0] bcc_bump_exp(input logic [1:0] cnt);
    if (cnt == 2'h3) begin
      return cnt;
    end
    return cnt + 2'h1;
  endfunction : bcc_bump_exp

  // ==========================================================
  // timer control and output mapping
  // start and stop are combinational so the timer reloads on the same
  // edge that moves the state; a registered start would add a cycle
  assign tif.start = start_d;
  assign tif.stop  = stop_d;

  // out_q bit order, msb first, follows the output port order
  assign {ind_alloc, ind_dealloc, ind_audit, ind_fault_conf, ind_fault_err,
          tx_alloc_cmpl, tx_alloc_rej, tx_dealloc_cmpl, tx_dealloc_rej,
          tx_audit_cmpl, tx_fault} = out_q;

  // ==========================================================
  // next-state logic
  // next state; every output but pending is a one-cycle pulse per event
  always_comb begin
    st_d    = st_q;
    nexp_d  = nexp_q;
    out_d   = 11'h000;
    start_d = 1'b0;
    stop_d  = 1'b0;
    case (st_q)
      bcc_pkg::BCC_OPER: begin
        // R2: peer indications
        out_d[10] = rx_alloc;
        out_d[9]  = rx_dealloc;
        out_d[8]  = rx_audit;
        // R3: complete responses
        out_d[5]  = mg_alloc_cmpl;
        out_d[3]  = mg_dealloc_cmpl;
        out_d[1]  = mg_audit_resp;
        // R4: reject responses
        out_d[4]  = mg_alloc_rej;
        out_d[2]  = mg_dealloc_rej;
        // R5: fault request
        if (mg_fault_req) begin
          out_d[0] = 1'b1;
          start_d  = 1'b1;
          // R10: fresh expiry count
          nexp_d   = 2'h0;
          st_d     = bcc_pkg::BCC_FAULT_PEND;
        end
      end
      bcc_pkg::BCC_FAULT_PEND: begin
        // R9: other events fall through ignored
        // ack wins over an expiry seen in the same cycle
        if (rx_fault_ack) begin
          // R6: confirm and stop timer
          out_d[7] = 1'b1;
          stop_d   = 1'b1;
          st_d     = bcc_pkg::BCC_OPER;
        end else if (tif.expire) begin
          nexp_d = bcc_bump_exp(nexp_q);
          if (bcc_bump_exp(nexp_q) >= `BCC_FRT_MAX_EXPIRY) begin
            // R8: give up after second expiry
            out_d[6] = 1'b1;
            st_d     = bcc_pkg::BCC_OPER;
          end else begin
            // R7: resend and restart
            out_d[0] = 1'b1;
            start_d  = 1'b1;
          end
        end
      end
      default: st_d = bcc_pkg::BCC_OPER;
    endcase
    // pending follows the next state so it never lags the message
    pending_d = (st_d == bcc_pkg::BCC_FAULT_PEND);
  end

  // ==========================================================
  // registers
  // R1: reset into operational state
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q    <= bcc_pkg::BCC_OPER;
      nexp_q  <= 2'h0;
      out_q   <= 11'h000;
      pending <= 1'b0;
    end else begin
      st_q    <= st_d;
      nexp_q  <= nexp_d;
      out_q   <= out_d;
      pending <= pending_d;
    end
  end

  // ==========================================================
  // assertions
  reset_oper_a: assert property (@(posedge clock) // R1
    sys_rst |=> st_q == bcc_pkg::BCC_OPER && !pending && out_q == 11'h000)
    else $error("not idle after reset");
  alloc_ind_a: assert property (@(posedge clock) disable iff (sys_rst) // R2
    st_q == bcc_pkg::BCC_OPER && rx_alloc |=> ind_alloc) else $error("allocation not indicated");
  audit_cmpl_a: assert property (@(posedge clock) disable iff (sys_rst) // R3
    st_q == bcc_pkg::BCC_OPER && mg_audit_resp |=> tx_audit_cmpl) else $error("no audit complete");
  dealloc_rej_a: assert property (@(posedge clock) disable iff (sys_rst) // R4
    st_q == bcc_pkg::BCC_OPER && mg_dealloc_rej |=> tx_dealloc_rej && st_q == bcc_pkg::BCC_OPER)
    else $error("no deallocation reject");
  fault_start_a: assert property (@(posedge clock) disable iff (sys_rst) // R5
    st_q == bcc_pkg::BCC_OPER && mg_fault_req |=> tx_fault && pending) else $error("fault not sent");
  fault_ack_a: assert property (@(posedge clock) disable iff (sys_rst) // R6
    st_q == bcc_pkg::BCC_FAULT_PEND && rx_fault_ack |=> ind_fault_conf && !pending)
    else $error("ack not confirmed");
  first_exp_a: assert property (@(posedge clock) disable iff (sys_rst) // R7
    st_q == bcc_pkg::BCC_FAULT_PEND && !rx_fault_ack && tif.expire && nexp_q == 2'h0
    |=> tx_fault && pending) else $error("no resend on first expiry");
  second_exp_a: assert property (@(posedge clock) disable iff (sys_rst) // R8
    st_q == bcc_pkg::BCC_FAULT_PEND && !rx_fault_ack && tif.expire && nexp_q == 2'h1
    |=> ind_fault_err && !tx_fault && !pending) else $error("no error on second expiry");
  pend_ignore_a: assert property (@(posedge clock) disable iff (sys_rst) // R9
    st_q == bcc_pkg::BCC_FAULT_PEND |=> !ind_alloc && !tx_alloc_cmpl && !ind_audit)
    else $error("event not ignored while pending");
  exp_clear_a: assert property (@(posedge clock) disable iff (sys_rst) // R10
    st_q == bcc_pkg::BCC_OPER && mg_fault_req |=> nexp_q == 2'h0) else $error("expiry count kept");
  // R2 to R4 for the event kinds not covered above
  dealloc_ind_a: assert property (@(posedge clock) disable iff (sys_rst) // R2
    st_q == bcc_pkg::BCC_OPER && rx_dealloc |=> ind_dealloc)
    else $error("deallocation not indicated");
  audit_ind_a: assert property (@(posedge clock) disable iff (sys_rst) // R2
    st_q == bcc_pkg::BCC_OPER && rx_audit |=> ind_audit)
    else $error("audit not indicated");
  alloc_cmpl_a: assert property (@(posedge clock) disable iff (sys_rst) // R3
    st_q == bcc_pkg::BCC_OPER && mg_alloc_cmpl |=> tx_alloc_cmpl)
    else $error("no allocation complete");
  dealloc_cmpl_a: assert property (@(posedge clock) disable iff (sys_rst) // R3
    st_q == bcc_pkg::BCC_OPER && mg_dealloc_cmpl |=> tx_dealloc_cmpl)
    else $error("no deallocation complete");
  alloc_rej_a: assert property (@(posedge clock) disable iff (sys_rst) // R4
    st_q == bcc_pkg::BCC_OPER && mg_alloc_rej |=> tx_alloc_rej)
    else $error("no allocation reject");
  oper_stay_a: assert property (@(posedge clock) disable iff (sys_rst) // R9
    st_q == bcc_pkg::BCC_OPER && !mg_fault_req |=> !pending)
    else $error("left operational state");
  // fault results never come out of the operational state
  conf_oper_a: assert property (@(posedge clock) disable iff (sys_rst) // R9
    st_q == bcc_pkg::BCC_OPER |=> !ind_fault_conf && !ind_fault_err)
    else $error("fault result while operational");
  pend_quiet_a: assert property (@(posedge clock) disable iff (sys_rst) // R9
    st_q == bcc_pkg::BCC_FAULT_PEND && !rx_fault_ack && !tif.expire |=> !tx_fault && pending)
    else $error("fault request not ignored");
  fault_pulse_a: assert property (@(posedge clock) disable iff (sys_rst) // R5
    tx_fault |=> !tx_fault)
    else $error("fault message longer than one cycle");
  // holds for any timer of three cycles or more
  ack_halt_a: assert property (@(posedge clock) disable iff (sys_rst) // R6
    st_q == bcc_pkg::BCC_FAULT_PEND && rx_fault_ack |=> !tif.expire [*4])
    else $error("timer ran on after acknowledge");

  // main scenarios: ack, give-up, resend, burst, reset while waiting
  c_ack_cv: cover property (@(posedge clock) ind_fault_conf);
  c_err_cv: cover property (@(posedge clock) ind_fault_err);
  c_resend_cv: cover property (@(posedge clock) pending && tx_fault);
  c_burst_cv: cover property (@(posedge clock) ind_alloc && ind_audit && tx_fault);
  c_rst_pend_cv: cover property (@(posedge clock) pending && sys_rst);
endmodule : bcc_an_fsm
`default_nettype wire

// >>> bcc_le_peer.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// exchange peer: acknowledges a fault message after a delay
module bcc_le_peer (
  input  wire logic       clock,
  input  wire logic       ack_en,
  input  wire logic [3:0] ack_dly,
  input  wire logic       tx_fault,
  output logic            rx_fault_ack
);
  int cnt = 0;
  initial rx_fault_ack = 1'b0;
  // countdown from each fault message; a silent peer lets the timer run out
  always @(negedge clock) begin
    rx_fault_ack <= 1'b0;
    if (tx_fault && ack_en) begin
      cnt <= int'(ack_dly);
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      rx_fault_ack <= (cnt == 1);
    end
  end
endmodule : bcc_le_peer
`default_nettype wire

// >>> bcc_params.svh
`ifndef BCC_PARAMS_SVH
`define BCC_PARAMS_SVH
// fault report timer in clock cycles (10 MHz clock)
`define BCC_FRT_CYCLES      32'h0000_0064
// number of timer expiries that end the fault report
`define BCC_FRT_MAX_EXPIRY  2'h2
`endif

// >>> bcc_pkg.sv
package bcc_pkg;
  typedef enum logic [0:0] {
    BCC_OPER = 1'b0,
    BCC_FAULT_PEND = 1'b1
  } bcc_state_t;
endpackage : bcc_pkg

// >>> bcc_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "bcc_params.svh"
// ==========================================================
// fault report timer
module bcc_timer #(
  parameter logic [31:0] CYCLES = `BCC_FRT_CYCLES
) (
  input  wire logic  clock,
  input  wire logic  sys_rst,
  bcc_tmr_if.tmr     tif
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        run_q;
  logic        run_d;
  logic        exp_q;
  logic        exp_d;

  assign tif.expire = exp_q;

  // start reloads; stop and expiry halt, one-cycle expiry pulse
  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    exp_d = 1'b0;
    if (tif.start) begin
      cnt_d = CYCLES - 32'h0000_0001;
      run_d = 1'b1;
    end else if (tif.stop) begin
      run_d = 1'b0;
    end else if (run_q) begin
      if (cnt_q == 32'h0000_0000) begin
        run_d = 1'b0;
        exp_d = 1'b1;
      end else begin
        cnt_d = cnt_q - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_q <= 32'h0000_0000;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      exp_q <= exp_d;
    end
  end
endmodule : bcc_timer
`default_nettype wire

// >>> bcc_tmr_if.sv
`timescale 1ns/100ps
`default_nettype none
// timer control travelling between the protocol machine and its timer
interface bcc_tmr_if;
  logic start;
  logic stop;
  logic expire;
  modport ctrl (output start, output stop, input expire);
  modport tmr  (input start, input stop, output expire);
endinterface : bcc_tmr_if
`default_nettype wire
